// File: tod_counter_regs.svh
// Function
// - Offset 0x00 holds upper sixteen seconds bits
// - Offset 0x04 holds lower seconds, resets zero
// - Offset 0x08 holds nanoseconds, resets zero
// - Offset 0x0C reserved, no function
// - Offset 0x10: fraction 15:0, whole 19:16
// - Increment resets to documented clock period
// - Offset 0x14 offset period, same layout, zero
// - Offset 0x18 cycles using offset period
// - Offset 0x1C drift value, added at correction
// - Offset 0x20 drift interval in cycles
// - Output: fraction, nanoseconds, seconds packed
// - One-cycle load strobe loads supplied time
`ifndef TOD_COUNTER_REGS_SVH
`define TOD_COUNTER_REGS_SVH

`define TOD_ADDR_W          4
`define TOD_OFS_SEC_HI      8'h00
`define TOD_OFS_SEC_LO      8'h04
`define TOD_OFS_NANOS       8'h08
`define TOD_OFS_RSVD        8'h0C
`define TOD_OFS_TICK        8'h10
`define TOD_OFS_OFS_STEP    8'h14
`define TOD_OFS_OFS_CYCLES  8'h18
`define TOD_OFS_DRIFT_VAL   8'h1C
`define TOD_OFS_DRIFT_INT   8'h20

`define TOD_FRAC_LSB        0
`define TOD_FRAC_MSB        15
`define TOD_WHOLE_LSB       16
`define TOD_WHOLE_MSB       19
`define TOD_SEC_HI_MSB      15
`define TOD_CYCLES_MSB      19
`define TOD_INTERVAL_MSB    15

`define TOD_TICK_WHOLE_RST  4'h8
`define TOD_TICK_FRAC_RST   16'h0000
`define TOD_NS_PER_SEC      32'h3B9A_CA00

`endif

// File: tod_counter_pkg.sv
package tod_counter_pkg;

  typedef struct packed {
    logic [3:0]  whole;
    logic [15:0] frac;
  } tod_period_t;

  typedef struct packed {
    logic [47:0] sec;
    logic [31:0] ns;
    logic [15:0] frac;
  } tod_time_t;

  // Byte offset to word index on the register port
  function automatic logic [3:0] tod_word(input logic [7:0] ofs);
    return ofs[5:2];
  endfunction : tod_word

endpackage : tod_counter_pkg

// File: tod_step_if.sv
`timescale 1ns/100ps
interface tod_step_if;
  import tod_counter_pkg::*;
  logic [31:0] cur_ns;
  logic [15:0] cur_frac;
  tod_period_t step;
  tod_period_t drift;
  logic        drift_en;
  logic [31:0] next_ns;
  logic [15:0] next_frac;
  logic        carry;

  modport core  (output cur_ns, cur_frac, step, drift, drift_en,
                 input  next_ns, next_frac, carry);
  modport adder (input  cur_ns, cur_frac, step, drift, drift_en,
                 output next_ns, next_frac, carry);
endinterface : tod_step_if

// File: tod_adder.sv
`timescale 1ns/100ps
`include "tod_counter_regs.svh"
module tod_adder
  import tod_counter_pkg::*;
(
  tod_step_if.adder step_if
);
  logic [47:0] base;
  logic [47:0] incr;
  logic [47:0] drift_add;
  logic [47:0] sum;
  logic        over;
  logic [31:0] wrapped;

  assign base      = {step_if.cur_ns, step_if.cur_frac};
  assign incr      = {28'h000_0000, step_if.step};
  assign drift_add = step_if.drift_en ? {28'h000_0000, step_if.drift}
                                      : 48'h0000_0000_0000;
  assign sum       = base + incr + drift_add;
  // One subtraction suffices: a step never exceeds a second
  assign over      = sum[47:16] >= `TOD_NS_PER_SEC;
  assign wrapped   = sum[47:16] - `TOD_NS_PER_SEC;

  assign step_if.next_ns   = over ? wrapped : sum[47:16];
  assign step_if.next_frac = sum[15:0];
  assign step_if.carry     = over;
endmodule : tod_adder

// File: tod_counter.sv
`timescale 1ns/100ps
`include "tod_counter_regs.svh"
module tod_counter
  import tod_counter_pkg::*;
#(
  parameter logic [3:0]  TICK_WHOLE_RST = `TOD_TICK_WHOLE_RST,
  parameter logic [15:0] TICK_FRAC_RST  = `TOD_TICK_FRAC_RST
)(
  input  wire logic                   clock_i,
  input  wire logic                   sys_rst_i,
  input  wire logic [`TOD_ADDR_W-1:0] csr_address_i,
  input  wire logic                   csr_read_i,
  input  wire logic                   csr_write_i,
  input  wire logic [31:0]            csr_writedata_i,
  output logic      [31:0]            csr_readdata_o,
  input  wire logic                   wide_time_load_strobe_i,
  input  wire logic [95:0]            wide_time_load_value_i,
  output logic      [95:0]            wide_time_output_o
);

  tod_step_if step_if ();

  logic [47:0] tod_seconds;
  logic [31:0] nanoseconds_count;
  logic [15:0] tod_fraction;
  tod_period_t tick_increment;
  tod_period_t offset_step_increment;
  logic [19:0] offset_step_cycles;
  tod_period_t drift_correction_value;
  logic [15:0] drift_correction_interval;
  logic [15:0] drift_cycle_count;

  logic        wr_sec_hi;
  logic        wr_sec_lo;
  logic        wr_nanos;
  logic        wr_tick;
  logic        wr_ofs_step;
  logic        wr_ofs_cycles;
  logic        wr_drift_val;
  logic        wr_drift_int;
  logic        drift_due;
  logic        adjusting;
  logic [47:0] next_seconds;
  logic [31:0] next_read;

  function automatic tod_period_t tod_period(input logic [31:0] d);
    tod_period_t p;
    p.whole = d[`TOD_WHOLE_MSB:`TOD_WHOLE_LSB];
    p.frac  = d[`TOD_FRAC_MSB:`TOD_FRAC_LSB];
    return p;
  endfunction : tod_period

  function automatic logic hit(input logic [7:0] ofs);
    return csr_write_i && (csr_address_i == tod_word(ofs));
  endfunction : hit

  assign wr_sec_hi     = hit(`TOD_OFS_SEC_HI);
  assign wr_sec_lo     = hit(`TOD_OFS_SEC_LO);
  assign wr_nanos      = hit(`TOD_OFS_NANOS);
  assign wr_tick       = hit(`TOD_OFS_TICK);
  assign wr_ofs_step   = hit(`TOD_OFS_OFS_STEP);
  assign wr_ofs_cycles = hit(`TOD_OFS_OFS_CYCLES);
  assign wr_drift_val  = hit(`TOD_OFS_DRIFT_VAL);
  assign wr_drift_int  = hit(`TOD_OFS_DRIFT_INT);

  // Interval of zero disables drift correction
  assign drift_due = (drift_correction_interval != 16'h0000) &&
                     (drift_cycle_count + 16'h0001 ==
                      drift_correction_interval);
  assign adjusting = offset_step_cycles != 20'h0_0000;

  assign step_if.cur_ns   = nanoseconds_count;
  assign step_if.cur_frac = tod_fraction;
  assign step_if.step     = adjusting ? offset_step_increment
                                      : tick_increment;
  assign step_if.drift    = drift_correction_value;
  assign step_if.drift_en = drift_due;

  tod_adder u_adder (
    .step_if (step_if)
  );

  assign next_seconds = tod_seconds + {47'h0000_0000_0000, step_if.carry};

  // Time counter: load strobe beats software writes beats advance
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tod_seconds       <= 48'h0000_0000_0000;
      nanoseconds_count <= 32'h0000_0000;
      tod_fraction      <= 16'h0000;
    end else if (wide_time_load_strobe_i) begin
      tod_seconds       <= wide_time_load_value_i[95:48];
      nanoseconds_count <= wide_time_load_value_i[47:16];
      tod_fraction      <= wide_time_load_value_i[15:0];
    end else begin
      tod_fraction      <= step_if.next_frac;
      nanoseconds_count <= wr_nanos ? csr_writedata_i
                                    : step_if.next_ns;
      if (wr_sec_hi) begin
        tod_seconds <= {csr_writedata_i[`TOD_SEC_HI_MSB:0],
                        next_seconds[31:0]};
      end else if (wr_sec_lo) begin
        tod_seconds <= {next_seconds[47:32], csr_writedata_i};
      end else begin
        tod_seconds <= next_seconds;
      end
    end
  end

  sec_hi_write_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (wr_sec_hi && !wide_time_load_strobe_i) |=>
      tod_seconds[47:32] == $past(csr_writedata_i[`TOD_SEC_HI_MSB:0]))
    else $error("upper seconds write not taken");

  sec_lo_write_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (wr_sec_lo && !wide_time_load_strobe_i) |=>
      tod_seconds[31:0] == $past(csr_writedata_i))
    else $error("lower seconds write not taken");

  ns_write_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (wr_nanos && !wide_time_load_strobe_i) |=>
      nanoseconds_count == $past(csr_writedata_i))
    else $error("nanoseconds write not taken");

  // Period settings
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_increment         <= '{whole: TICK_WHOLE_RST,
                                  frac: TICK_FRAC_RST};
      offset_step_increment  <= '{whole: 4'h0, frac: 16'h0000};
      drift_correction_value <= '{whole: 4'h0, frac: 16'h0000};
    end else begin
      if (wr_tick) begin
        tick_increment <= tod_period(csr_writedata_i);
      end
      if (wr_ofs_step) begin
        offset_step_increment <= tod_period(csr_writedata_i);
      end
      if (wr_drift_val) begin
        drift_correction_value <= tod_period(csr_writedata_i);
      end
    end
  end

  // Offset adjustment: the count register reads back cycles left
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      offset_step_cycles <= 20'h0_0000;
    end else if (wr_ofs_cycles) begin
      offset_step_cycles <= csr_writedata_i[`TOD_CYCLES_MSB:0];
    end else if (adjusting) begin
      offset_step_cycles <= offset_step_cycles - 20'h0_0001;
    end
  end

  offset_end_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (offset_step_cycles == 20'h0_0001 && !wr_ofs_cycles) |=>
      (!adjusting && step_if.step == tick_increment))
    else $error("offset adjustment ran past its cycle count");

  // Drift interval and its cycle counter
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drift_correction_interval <= 16'h0000;
      drift_cycle_count         <= 16'h0000;
    end else begin
      if (wr_drift_int) begin
        drift_correction_interval <=
          csr_writedata_i[`TOD_INTERVAL_MSB:0];
      end
      // Restart the count so a new interval starts cleanly
      if (wr_drift_int || drift_due) begin
        drift_cycle_count <= 16'h0000;
      end else if (drift_correction_interval != 16'h0000) begin
        drift_cycle_count <= drift_cycle_count + 16'h0001;
      end
    end
  end

  // Carry cycles left out: the wrap is checked on its own
  drift_add_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (drift_due && !wide_time_load_strobe_i && !wr_nanos &&
     !step_if.carry) |=>
      {nanoseconds_count, tod_fraction} ==
        $past({nanoseconds_count, tod_fraction}) +
        $past({28'h000_0000, step_if.step}) +
        $past({28'h000_0000, step_if.drift}))
    else $error("drift value not added when due");

  always_comb begin
    next_read = 32'h0000_0000;
    case (csr_address_i)
      tod_word(`TOD_OFS_SEC_HI):     next_read = {16'h0000,
                                                  tod_seconds[47:32]};
      tod_word(`TOD_OFS_SEC_LO):     next_read = tod_seconds[31:0];
      tod_word(`TOD_OFS_NANOS):      next_read = nanoseconds_count;
      tod_word(`TOD_OFS_TICK):       next_read = {12'h000,
                                                  tick_increment};
      tod_word(`TOD_OFS_OFS_STEP):   next_read = {12'h000,
                                                  offset_step_increment};
      tod_word(`TOD_OFS_OFS_CYCLES): next_read = {12'h000,
                                                  offset_step_cycles};
      tod_word(`TOD_OFS_DRIFT_VAL):  next_read = {12'h000,
                                                  drift_correction_value};
      tod_word(`TOD_OFS_DRIFT_INT):  next_read = {16'h0000,
                                              drift_correction_interval};
      default:                       next_read = 32'h0000_0000;
    endcase
  end

  // Read data registered, valid the cycle after the read strobe
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      csr_readdata_o <= 32'h0000_0000;
    end else if (csr_read_i) begin
      csr_readdata_o <= next_read;
    end
  end

  sec_lo_read_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (csr_read_i && csr_address_i == tod_word(`TOD_OFS_SEC_LO))
      |=> csr_readdata_o == $past(tod_seconds[31:0]))
    else $error("lower seconds read wrong");

  ns_read_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (csr_read_i && csr_address_i == tod_word(`TOD_OFS_NANOS))
      |=> csr_readdata_o == $past(nanoseconds_count))
    else $error("nanoseconds read wrong");

  tick_read_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (csr_read_i && csr_address_i == tod_word(`TOD_OFS_TICK))
      |=> csr_readdata_o == {12'h000, $past(tick_increment)})
    else $error("increment read wrong");

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wide_time_output_o <= 96'h0;
    end else begin
      wide_time_output_o <= {tod_seconds, nanoseconds_count,
                             tod_fraction};
    end
  end

  load_time_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    wide_time_load_strobe_i |=> ##1
      wide_time_output_o == $past(wide_time_load_value_i, 2))
    else $error("load value not on output two cycles later");

  sec_carry_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (!wide_time_load_strobe_i && !wr_sec_hi && !wr_sec_lo &&
     step_if.carry) |=> tod_seconds == $past(tod_seconds) + 48'h1)
    else $error("seconds did not advance on nanosecond wrap");

  ns_range_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (!wide_time_load_strobe_i && !wr_nanos &&
     nanoseconds_count < `TOD_NS_PER_SEC)
      |=> nanoseconds_count < `TOD_NS_PER_SEC)
    else $error("nanoseconds left legal range");

  sec_hi_read_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (csr_read_i && csr_address_i == tod_word(`TOD_OFS_SEC_HI))
      |=> csr_readdata_o == {16'h0000, $past(tod_seconds[47:32])})
    else $error("upper seconds read wrong");

  rsvd_read_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (csr_read_i && csr_address_i == tod_word(`TOD_OFS_RSVD))
      |=> csr_readdata_o == 32'h0000_0000)
    else $error("reserved word did not read zero");

  tick_use_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (wr_tick && !wr_ofs_cycles && !adjusting) |=>
      !adjusting |-> step_if.step == $past(csr_writedata_i[`TOD_WHOLE_MSB:0]))
    else $error("written increment not used as period");

  offset_run_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (adjusting && !wr_ofs_cycles) |->
      step_if.step == offset_step_increment ##1
      offset_step_cycles == $past(offset_step_cycles) - 20'h0_0001)
    else $error("offset adjustment count or period wrong");

  drift_gap_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (drift_due && drift_correction_interval > 16'h0001 &&
     !wr_drift_int) |=> !drift_due)
    else $error("drift correction applied on consecutive cycles");

  drift_off_a: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (drift_correction_interval == 16'h0000 &&
     !wide_time_load_strobe_i && !wr_nanos && !step_if.carry) |=>
      {nanoseconds_count, tod_fraction} ==
        $past({nanoseconds_count, tod_fraction}) +
        $past({28'h000_0000, step_if.step}))
    else $error("drift added while interval is zero");

endmodule : tod_counter

// File: tod_sync_master.sv
`timescale 1ns/100ps
module tod_sync_master
  import tod_counter_pkg::*;
(
  input  wire logic        clock_i,
  output logic             load_strobe_o,
  output logic [95:0]      load_value_o
);
  initial begin
    load_strobe_o = 1'b0;
    load_value_o  = '0;
  end

  // Value is scrambled once the pulse is over, never left valid
  task automatic send(input tod_time_t value);
    @(posedge clock_i);
    load_strobe_o <= 1'b1;
    load_value_o  <= value;
    @(posedge clock_i);
    load_strobe_o <= 1'b0;
    load_value_o  <= ~value;
  endtask : send
endmodule : tod_sync_master

// File: testbench.sv
`timescale 1ns/100ps
`include "tod_counter_regs.svh"
module testbench;
  import tod_counter_pkg::*;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  csr_address_i = 4'h0;
  logic        csr_read_i = 1'b0;
  logic        csr_write_i = 1'b0;
  logic [31:0] csr_writedata_i = 32'h0000_0000;
  logic [31:0] csr_readdata_o;
  logic        load_strobe;
  logic [95:0] load_value;
  logic [95:0] wide_time_output_o;
  int          errors = 0;
  int          n_compared = 0;
  int          seed = 48;

  tod_counter dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .csr_address_i(csr_address_i), .csr_read_i(csr_read_i),
    .csr_write_i(csr_write_i), .csr_writedata_i(csr_writedata_i),
    .csr_readdata_o(csr_readdata_o), .wide_time_load_strobe_i(load_strobe),
    .wide_time_load_value_i(load_value),
    .wide_time_output_o(wide_time_output_o));
  tod_sync_master master (.clock_i(clock_i), .load_strobe_o(load_strobe),
    .load_value_o(load_value));

  always #25 clock_i = ~clock_i;

  // Whole time in units of 2^-16 ns, so differences survive carries
  function automatic logic [127:0] flat(input tod_time_t t);
    return ((128'(t.sec) * `TOD_NS_PER_SEC + 128'(t.ns)) << 16) | t.frac;
  endfunction : flat

  function automatic logic [127:0] span(input int m, input logic [19:0] per,
                                        input int i, input logic [19:0] dr);
    return 128'(m) * per + ((i == 0) ? 128'h0 : 128'(m / i) * dr);
  endfunction : span

  task automatic check(input string what, input logic [127:0] exp,
                       input logic [127:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    @(posedge clock_i);
    csr_address_i   <= ofs[5:2];
    csr_writedata_i <= d;
    csr_write_i     <= 1'b1;
    @(posedge clock_i);
    csr_write_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ofs, output logic [31:0] d);
    @(posedge clock_i);
    csr_address_i <= ofs[5:2];
    csr_read_i    <= 1'b1;
    @(posedge clock_i);
    csr_read_i <= 1'b0;
    #1;
    d = csr_readdata_o;
  endtask : rd

  task automatic rd_chk(input string what, input logic [7:0] ofs,
                        input logic [31:0] exp);
    logic [31:0] d;
    rd(ofs, d);
    check(what, exp, d);
  endtask : rd_chk

  // Samples the time, writes at the window's second edge, samples again m edges later
  task automatic win(input int m, input logic [7:0] ofs,
                     input logic [31:0] d, output logic [127:0] diff);
    logic [127:0] o1;
    @(posedge clock_i);
    #1;
    o1 = flat(wide_time_output_o);
    wr(ofs, d);
    repeat (m - 2) @(posedge clock_i);
    #1;
    diff = flat(wide_time_output_o) - o1;
  endtask : win

  task automatic wrap_up;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial begin
    #(50 * 20000);
    errors++;
    wrap_up();
  end

  initial begin
    logic [31:0]  d, x;
    logic [19:0]  tick, ostep, dval;
    logic [127:0] diff;
    tod_time_t    v;
    int           n, ivl;
    repeat (9) @(posedge clock_i);
    #1;
    check("time in reset", 96'h0, wide_time_output_o);
    @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd_chk("seconds_upper", 8'h00, 32'h0000_0000);
    rd_chk("seconds_lower", 8'h04, 32'h0000_0000);
    rd_chk("tick_increment", 8'h10, 32'h0008_0000);
    rd_chk("offset_step_increment", 8'h14, 32'h0000_0000);
    rd_chk("offset_step_cycles", 8'h18, 32'h0000_0000);
    rd_chk("drift_correction_value", 8'h1C, 32'h0000_0000);
    rd_chk("drift_correction_interval", 8'h20, 32'h0000_0000);
    rd(8'h08, d);
    check("ns after reset", 1, d < 400);
    x = 32'($unsigned($random(seed))) % 32'd900_000_000;
    wr(8'h08, x);
    rd(8'h08, d);
    check("ns written", 1, (d - x) < 64);
    wr(8'h0C, $random(seed));
    rd_chk("reserved", 8'h0C, 32'h0000_0000);
    wr(8'h30, $random(seed));
    rd_chk("unmapped", 8'h30, 32'h0000_0000);
    x = $random(seed);
    wr(8'h00, x);
    rd_chk("seconds_upper", 8'h00, x & 32'h0000_FFFF);
    wr(8'h04, x);
    rd_chk("seconds_lower", 8'h04, x);
    wr(8'h1C, x);
    rd_chk("drift_correction_value", 8'h1C, x & 32'h000F_FFFF);
    wr(8'h20, x);
    rd_chk("drift_correction_interval", 8'h20, x & 32'h0000_FFFF);
    wr(8'h20, 32'h0000_0000);
    wr(8'h14, x);
    rd_chk("offset_step_increment", 8'h14, x & 32'h000F_FFFF);
    x = $random(seed) | 32'h0001_0000;
    wr(8'h10, x);
    rd_chk("tick_increment", 8'h10, x & 32'h000F_FFFF);
    tick = x[19:0];
    v.sec  = {16'($random(seed)), 32'($random(seed))};
    v.ns   = 32'd999_999_990;
    v.frac = 16'($random(seed));
    master.send(v);
    @(posedge clock_i);
    #1;
    check("loaded time", v, wide_time_output_o);
    win(10, 8'h0C, 32'h0000_0000, diff);
    check("carry span", span(10, tick, 0, 0), diff);
    check("ns below one second", 1,
          wide_time_output_o[47:16] < `TOD_NS_PER_SEC);
    check("seconds carried", v.sec + 48'h1, wide_time_output_o[95:48]);
    rd_chk("seconds_lower", 8'h04, 32'(v.sec + 48'h1));
    rd_chk("seconds_upper", 8'h00, {16'h0000, 16'((v.sec + 48'h1) >> 32)});
    for (int k = 0; k < 8; k++) begin
      tick  = {4'($unsigned($random(seed)) % 15 + 1), 16'($random(seed))};
      ostep = 20'($random(seed));
      dval  = 20'($random(seed));
      n     = (k == 0) ? 1 : $unsigned($random(seed)) % 20 + 1;
      ivl   = (k == 0) ? 1 : $unsigned($random(seed)) % 9 + 2;
      wr(8'h10, {12'h000, tick});
      wr(8'h14, {12'h000, ostep});
      win(n + 8, 8'h18, 32'(n), diff);
      check("offset span", span(8, tick, 0, 0) + span(n, ostep, 0, 0),
            diff);
      rd_chk("offset_step_cycles", 8'h18, 32'h0000_0000);
      wr(8'h1C, {12'h000, dval});
      wr(8'h20, 32'(ivl));
      win(4 * ivl, 8'h0C, 32'h0000_0000, diff);
      check("drift span", span(4 * ivl, tick, ivl, dval), diff);
      wr(8'h20, 32'h0000_0000);
    end
    wrap_up();
  end
endmodule : testbench
